// ---- sfd_params.svh ----
// register map, field positions, reset values and timing counts of the serial port
// Contract
// - receive bits enter the receive shift register least significant bit first
// - a finished byte moves to the receive buffer; shifter is free again
// - both shift registers stay internal, no software access
// - receive buffer is read-only, cleared by reset and standby
// - an empty transmit shifter takes the buffer byte, sends bit 0 first
// - after a byte, next buffer byte follows; empty flag set means no transfer
// - software may refill the buffer while the shifter is busy
// - transmit buffer is read/write, set to all ones by reset and standby
// - format register is read/write, cleared by reset and standby
// - format bit 7 picks asynchronous or clocked synchronous mode
// - format bit 6 picks 8 or 7 asynchronous data bits; synchronous is 8
// - with 7-bit characters the top buffer bit is not sent
// - format bit 5 adds and checks parity, asynchronous mode only
// - format bit 4 picks even or odd parity
// - parity makes the ones count of data plus parity even or odd
// - format bit 3 gives one or two stop bits of value 1 on transmit
// - receiver checks only the first stop bit
// - format bit 2 enables multiprocessor bit and overrides parity settings
// - two prescale bits divide the system clock by 1, 4, 16 or 64
// - buffer write with transmit on clears empty flag; transmit off holds it 1
// - every move into the receive buffer sets the buffer full flag
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH
`define SFD_A_FMT 3'h0
`define SFD_A_BRR 3'h1
`define SFD_A_CTRL 3'h2
`define SFD_A_TXB 3'h3
`define SFD_A_STAT 3'h4
`define SFD_A_RXB 3'h5
`define SFD_C_TXEN 5
`define SFD_C_RXEN 4
`define SFD_C_MPBT 0
`define SFD_S_TX_BUFFER_EMPTY_FLAG 7
`define SFD_S_RX_BUFFER_FULL_FLAG 6
`define SFD_S_FER 5
`define SFD_S_PER 4
`define SFD_S_MPBR 1
`define SFD_RST_FMT 8'h00
`define SFD_RST_BRR 8'hff
`define SFD_RST_TXB 8'hff
`define SFD_RST_RXB 8'h00
`define SFD_OSR 4'hf
`define SFD_MID 4'h7
`define SFD_PS1 6'h00
`define SFD_PS4 6'h03
`define SFD_PS16 6'h0f
`define SFD_PS64 6'h3f
`endif

// ---- sfd_pkg.sv ----
// types shared by the serial port modules
package sfd_pkg;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP = 3'b100
    } sfd_tx_e;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } sfd_rx_e;
    typedef struct packed {
        logic com;
        logic chr;
        logic pe;
        logic pm;
        logic stop;
        logic mp;
        logic [1:0] cks;
    } sfd_fmt_s;
    typedef struct packed {
        logic [5:0] pre;
        logic [7:0] cnt;
    } sfd_baud_s;
    typedef struct packed {
        sfd_fmt_s fmt;
        logic [7:0] brr;
        logic tx_en;
        logic rx_en;
        logic mpbt;
        logic [7:0] tx_data_buffer;
        logic tx_buffer_empty_flag;
        logic [7:0] tx_shift_register;
        sfd_tx_e txs;
        logic [3:0] tsub;
        logic [2:0] tbit;
        logic tpar;
        logic tstp2;
        logic txd;
        logic sck;
        logic [7:0] rx_data_buffer;
        logic rx_buffer_full_flag;
        logic fer;
        logic per;
        logic mpbr;
        logic [7:0] rx_shift_register;
        sfd_rx_e rxs;
        logic [3:0] rsub;
        logic [2:0] rbit;
        logic rpar;
        logic [2:0] sy;
        logic rxf;
        logic [7:0] rdata;
    } sfd_core_s;
endpackage : sfd_pkg

// ---- sfd_baud.sv ----
// baud tick generator: clock prescaler followed by a programmable divider
`include "sfd_params.svh"
module sfd_baud
    import sfd_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] cks_i,
    input wire logic [7:0] div_i,
    output logic tick_o
);
    sfd_baud_s s_q;
    sfd_baud_s s_d;

    function automatic logic [5:0] pre_top(input logic [1:0] sel);
        case (sel)
            2'b00: pre_top = `SFD_PS1;
            2'b01: pre_top = `SFD_PS4;
            2'b10: pre_top = `SFD_PS16;
            default: pre_top = `SFD_PS64;
        endcase
    endfunction : pre_top

    always_comb begin
        s_d = s_q;
        tick_o = 1'b0;
        if (s_q.pre >= pre_top(cks_i)) begin
            s_d.pre = 6'h00;
            if (s_q.cnt >= div_i) begin
                s_d.cnt = 8'h00;
                tick_o = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end else begin
            s_d.pre = s_q.pre + 6'h01;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    property p_undivided;
        @(posedge clk_i) disable iff (!nrst_i)
        (cks_i == 2'b00 && div_i == 8'h00) |-> tick_o;
    endproperty
    a_undivided: assert property (p_undivided) else $error("undivided clock gave no tick");
    property p_div4_gap;
        @(posedge clk_i) disable iff (!nrst_i)
        (tick_o && cks_i == 2'b01 && div_i == 8'h00) ##1 (cks_i == 2'b01 && div_i == 8'h00)
        |-> !tick_o;
    endproperty
    a_div4_gap: assert property (p_div4_gap) else $error("divide by four ticked early");
endmodule : sfd_baud

// ---- sfd_core.sv ----
// serial port data path: format register, double-buffered transmit and receive
//
// Local design decisions: the register offsets and the plain strobed port.
`include "sfd_params.svh"
module sfd_core
    import sfd_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic standby_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic sck_o
);
    sfd_core_s s_q;
    sfd_core_s s_d;
    logic tick;
    logic tx_load;
    logic rx_done;
    logic rx_smp;
    logic tx_end;
    logic [7:0] rx_word;

    function automatic sfd_core_s rst_val();
        sfd_core_s r;
        r = '0;
        r.fmt = sfd_fmt_s'(`SFD_RST_FMT);
        r.brr = `SFD_RST_BRR;
        r.tx_data_buffer = `SFD_RST_TXB;
        r.rx_data_buffer = `SFD_RST_RXB;
        r.tx_buffer_empty_flag = 1'b1;
        r.txd = 1'b1;
        r.sck = 1'b1;
        r.sy = 3'b111;
        r.rxf = 1'b1;
        return r;
    endfunction : rst_val

    localparam sfd_core_s RST = rst_val();

    // index of the last data bit of a character
    function automatic logic [2:0] last_f(input sfd_fmt_s f);
        last_f = (f.chr && !f.com) ? 3'h6 : 3'h7;
    endfunction : last_f

    // parity or multiprocessor bit needed after the data
    function automatic logic extra_f(input sfd_fmt_s f);
        extra_f = !f.com && (f.pe || f.mp);
    endfunction : extra_f

    function automatic sfd_core_s tx_load_f(input sfd_core_s x);
        sfd_core_s y;
        logic [7:0] dat;
        y = x;
        dat = x.tx_data_buffer;
        if (x.fmt.chr && !x.fmt.com) begin
            dat[7] = 1'b0;
        end
        y.tx_shift_register = x.tx_data_buffer;
        y.tx_buffer_empty_flag = 1'b1;
        y.tsub = 4'h0;
        y.tbit = 3'h0;
        y.tstp2 = 1'b0;
        y.tpar = x.fmt.mp ? x.mpbt : ((^dat) ^ x.fmt.pm);
        if (x.fmt.com) begin
            y.txs = TX_DATA;
            y.txd = x.tx_data_buffer[0];
            y.sck = 1'b0;
        end else begin
            y.txs = TX_START;
            y.txd = 1'b0;
        end
        return y;
    endfunction : tx_load_f

    sfd_baud u_baud (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .cks_i(s_q.fmt.cks),
        .div_i(s_q.brr),
        .tick_o(tick)
    );

    // 7-bit frames land one place high after shifting
    assign rx_word = (s_q.fmt.chr && !s_q.fmt.com) ? {1'b0, s_q.rx_shift_register[7:1]} : s_q.rx_shift_register;

    always_comb begin
        s_d = s_q;
        tx_load = 1'b0;
        rx_done = 1'b0;
        rx_smp = tick && (s_q.rsub == `SFD_OSR);
        tx_end = tick && (s_q.tsub == `SFD_OSR);

        // read data stands only in the cycle after the strobe
        s_d.rdata = 8'h00;
        if (re_i) begin
            if (addr_i == `SFD_A_FMT) begin
                s_d.rdata = s_q.fmt;
            end else if (addr_i == `SFD_A_BRR) begin
                s_d.rdata = s_q.brr;
            end else if (addr_i == `SFD_A_CTRL) begin
                s_d.rdata = {2'b00, s_q.tx_en, s_q.rx_en, 3'b000, s_q.mpbt};
            end else if (addr_i == `SFD_A_TXB) begin
                s_d.rdata = s_q.tx_data_buffer;
            end else if (addr_i == `SFD_A_STAT) begin
                s_d.rdata = {s_q.tx_buffer_empty_flag, s_q.rx_buffer_full_flag, s_q.fer, s_q.per, 2'b00, s_q.mpbr, 1'b0};
            end else if (addr_i == `SFD_A_RXB) begin
                s_d.rdata = s_q.rx_data_buffer;
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        // transmitter
        if (tick && s_q.txs != TX_IDLE) begin
            s_d.tsub = s_q.tsub + 4'h1;
        end
        case (s_q.txs)
            TX_IDLE: begin
                s_d.txd = 1'b1;
                s_d.sck = 1'b1;
                if (s_q.tx_en && !s_q.tx_buffer_empty_flag) begin
                    s_d = tx_load_f(s_d);
                    tx_load = 1'b1;
                end
            end
            TX_START: begin
                if (tx_end) begin
                    s_d.txs = TX_DATA;
                    s_d.txd = s_q.tx_shift_register[0];
                end
            end
            TX_DATA: begin
                if (s_q.fmt.com && tick && s_q.tsub == `SFD_MID) begin
                    s_d.sck = 1'b1;
                    if (s_q.rx_en) begin
                        s_d.rx_shift_register = {s_q.rxf, s_q.rx_shift_register[7:1]};
                    end
                end
                if (tx_end) begin
                    s_d.tx_shift_register = {1'b1, s_q.tx_shift_register[7:1]};
                    if (s_q.tbit != last_f(s_q.fmt)) begin
                        s_d.tbit = s_q.tbit + 3'h1;
                        s_d.txd = s_q.tx_shift_register[1];
                        s_d.sck = !s_q.fmt.com;
                    end else if (s_q.fmt.com) begin
                        // no parity and no stop bit in clocked mode
                        rx_done = s_q.rx_en;
                        s_d.txs = TX_IDLE;
                        s_d.sck = 1'b1;
                        if (s_q.tx_en && !s_q.tx_buffer_empty_flag) begin
                            s_d = tx_load_f(s_d);
                            tx_load = 1'b1;
                        end
                    end else if (extra_f(s_q.fmt)) begin
                        s_d.txs = TX_PAR;
                        s_d.txd = s_q.tpar;
                    end else begin
                        s_d.txs = TX_STOP;
                        s_d.txd = 1'b1;
                        s_d.tstp2 = s_q.fmt.stop;
                    end
                end
            end
            TX_PAR: begin
                if (tx_end) begin
                    s_d.txs = TX_STOP;
                    s_d.txd = 1'b1;
                    s_d.tstp2 = s_q.fmt.stop;
                end
            end
            TX_STOP: begin
                if (tx_end) begin
                    if (s_q.tstp2) begin
                        s_d.tstp2 = 1'b0;
                    end else begin
                        s_d.txs = TX_IDLE;
                        if (s_q.tx_en && !s_q.tx_buffer_empty_flag) begin
                            s_d = tx_load_f(s_d);
                            tx_load = 1'b1;
                        end
                    end
                end
            end
            default: begin
                s_d.txs = TX_IDLE;
            end
        endcase

        // software writes; a buffer write after a load keeps the new byte pending
        if (we_i) begin
            if (addr_i == `SFD_A_FMT) begin
                s_d.fmt = sfd_fmt_s'(wdata_i);
            end else if (addr_i == `SFD_A_BRR) begin
                s_d.brr = wdata_i;
            end else if (addr_i == `SFD_A_CTRL) begin
                s_d.tx_en = wdata_i[`SFD_C_TXEN];
                s_d.rx_en = wdata_i[`SFD_C_RXEN];
                s_d.mpbt = wdata_i[`SFD_C_MPBT];
            end else if (addr_i == `SFD_A_TXB) begin
                s_d.tx_data_buffer = wdata_i;
                if (s_q.tx_en) begin
                    s_d.tx_buffer_empty_flag = 1'b0;
                end
            end else if (addr_i == `SFD_A_STAT) begin
                s_d.rx_buffer_full_flag = s_q.rx_buffer_full_flag & wdata_i[`SFD_S_RX_BUFFER_FULL_FLAG];
                s_d.fer = s_q.fer & wdata_i[`SFD_S_FER];
                s_d.per = s_q.per & wdata_i[`SFD_S_PER];
            end
        end

        // receiver; placed after the flag clears so a new event wins
        if (tick && s_q.rxs != RX_IDLE) begin
            s_d.rsub = s_q.rsub + 4'h1;
        end
        case (s_q.rxs)
            RX_IDLE: begin
                if (s_q.rx_en && !s_q.fmt.com && !s_q.rxf) begin
                    s_d.rxs = RX_START;
                    s_d.rsub = 4'h0;
                end
            end
            RX_START: begin
                // half a bit later the line must still be low, else a glitch
                if (tick && s_q.rsub == `SFD_MID) begin
                    s_d.rsub = 4'h0;
                    s_d.rbit = 3'h0;
                    s_d.rxs = s_q.rxf ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_smp) begin
                    s_d.rx_shift_register = {s_q.rxf, s_q.rx_shift_register[7:1]};
                    s_d.rbit = s_q.rbit + 3'h1;
                    if (s_q.rbit == last_f(s_q.fmt)) begin
                        s_d.rxs = extra_f(s_q.fmt) ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_smp) begin
                    s_d.rpar = s_q.rxf;
                    s_d.rxs = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_smp) begin
                    // only this first stop bit is judged
                    rx_done = 1'b1;
                    s_d.rxs = RX_IDLE;
                    if (!s_q.rxf) begin
                        s_d.fer = 1'b1;
                    end
                    if (s_q.fmt.pe && !s_q.fmt.mp && ((^rx_word) ^ s_q.rpar ^ s_q.fmt.pm)) begin
                        s_d.per = 1'b1;
                    end
                    if (s_q.fmt.mp) begin
                        s_d.mpbr = s_q.rpar;
                    end
                end
            end
            default: begin
                s_d.rxs = RX_IDLE;
            end
        endcase
        if (rx_done) begin
            s_d.rx_data_buffer = rx_word;
            s_d.rx_buffer_full_flag = 1'b1;
        end

        if (!s_q.tx_en) begin
            s_d.tx_buffer_empty_flag = 1'b1;
        end

        // three-stage pin input; a level is accepted once stages two and three agree
        s_d.sy = {s_q.sy[1:0], rxd_i};
        if (s_q.sy[1] == s_q.sy[2]) begin
            s_d.rxf = s_q.sy[2];
        end

        if (standby_i) begin
            s_d = RST;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign txd_o = s_q.txd;
    assign sck_o = s_q.sck;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    property p_rx_lsb;
        (s_q.rxs == RX_DATA && rx_smp && !standby_i) |=> s_q.rx_shift_register[7] == $past(s_q.rxf);
    endproperty
    a_rx_lsb: assert property (p_rx_lsb) else $error("receive bit not shifted in at top");

    property p_rx_move;
        (rx_done && !standby_i) |=> s_q.rx_buffer_full_flag && s_q.rx_data_buffer == $past(rx_word);
    endproperty
    a_rx_move: assert property (p_rx_move) else $error("received byte not moved to buffer");

    property p_unmapped;
        (re_i && addr_i > `SFD_A_RXB) |=> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_rdr_ro;
        (we_i && addr_i == `SFD_A_RXB && !rx_done && !standby_i) |=> $stable(s_q.rx_data_buffer);
    endproperty
    a_rdr_ro: assert property (p_rdr_ro) else $error("receive buffer was written");

    property p_standby;
        standby_i |=> s_q.rx_data_buffer == `SFD_RST_RXB && s_q.tx_data_buffer == `SFD_RST_TXB && s_q.fmt == `SFD_RST_FMT;
    endproperty
    a_standby: assert property (p_standby) else $error("standby did not reinitialise");

    property p_load;
        (tx_load && !standby_i && !(we_i && addr_i == `SFD_A_TXB))
        |=> s_q.tx_shift_register == $past(s_q.tx_data_buffer) && s_q.tx_buffer_empty_flag;
    endproperty
    a_load: assert property (p_load) else $error("shift register not loaded from buffer");

    property p_no_start;
        (s_q.txs == TX_IDLE && s_q.tx_buffer_empty_flag) |=> s_q.txs == TX_IDLE;
    endproperty
    a_no_start: assert property (p_no_start) else $error("transmit started with empty buffer");

    property p_start_low;
        (s_q.txs == TX_START) |-> txd_o == 1'b0;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");

    property p_stop_high;
        (s_q.txs == TX_STOP) |-> txd_o == 1'b1 && !s_q.fmt.com;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit wrong");

    property p_sync_nopar;
        (s_q.fmt.com && s_q.txs == TX_DATA && !(we_i && addr_i == `SFD_A_FMT)) |=> s_q.txs != TX_PAR;
    endproperty
    a_sync_nopar: assert property (p_sync_nopar) else $error("parity in clocked mode");

    property p_tx_buffer_empty_flag_off;
        !s_q.tx_en |=> s_q.tx_buffer_empty_flag;
    endproperty
    a_tx_buffer_empty_flag_off: assert property (p_tx_buffer_empty_flag_off) else $error("empty flag low with transmit off");

    property p_tdr_wr;
        (we_i && addr_i == `SFD_A_TXB && s_q.tx_en && !standby_i) |=> !s_q.tx_buffer_empty_flag ##1 1'b1;
    endproperty
    a_tdr_wr: assert property (p_tdr_wr) else $error("buffer write left empty flag set");
endmodule : sfd_core

// ---- sfd_peer.sv ----
// far-side serial device: drives the receive pin and samples the port's outputs
module sfd_peer (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic sck_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_o = 1'b1;
    // frame bits leave lsb first, each held one bit period
    task automatic send(input logic [23:0] f, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (per - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask : send
    // sampled on the falling clock so the port's registered pin has settled
    task automatic capture(input int n, input int per, output logic [23:0] f, output bit ok);
        int k;
        f = '1;
        ok = 1'b0;
        for (k = 0; k < 2 * per + 40 && !ok; k++) begin
            @(negedge clk_i);
            ok = (txd_i === 1'b0);
        end
        repeat (per / 2) @(negedge clk_i);
        for (int i = 0; i < n; i++) begin
            f[i] = txd_i;
            repeat (per) @(negedge clk_i);
        end
    endtask : capture
    // new bit only after the clock falls, so the rising sample never sees it move
    task automatic sync_xfer(input logic [7:0] d, output logic [7:0] got, output bit ok);
        int k;
        ok = 1'b1;
        @(posedge clk_i);
        line_o <= d[0];
        for (int i = 0; i < 8; i++) begin
            for (k = 0; k < 300 && sck_i !== 1'b0; k++) @(negedge clk_i);
            for (k = 0; k < 300 && sck_i !== 1'b1; k++) @(negedge clk_i);
            got[i] = txd_i;
            ok &= (k < 300);
            if (i < 7) begin
                for (k = 0; k < 300 && sck_i === 1'b1; k++) @(negedge clk_i);
                @(posedge clk_i);
                line_o <= d[i + 1];
            end
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask : sync_xfer
endmodule : sfd_peer

// ---- tb_top.sv ----
// self-checking bench for the serial port data path
`include "sfd_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic we;
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } sfd_row_s;
    typedef struct packed {
        logic [7:0] fmt;
        logic [7:0] brr;
        logic [7:0] ctl;
        logic [7:0] d;
    } sfd_tx_s;
    typedef struct packed {
        logic [7:0] fmt;
        logic [7:0] d;
        logic [23:0] flip;
        logic [7:0] st;
    } sfd_rx_s;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic standby_i = 1'b0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o, last, h8;
    logic rxd, txd_o, sck_o;
    logic [23:0] f, g, h;
    int bad_count = 0;
    int check_count = 0;
    int n, per, k;
    bit ok;
    sfd_row_s regs [13] = '{
        '{0, `SFD_A_FMT, 8'h00, 8'h00}, '{0, `SFD_A_TXB, 8'h00, 8'hff},
        '{0, `SFD_A_RXB, 8'h00, 8'h00}, '{0, `SFD_A_STAT, 8'h00, 8'h80},
        '{1, `SFD_A_RXB, 8'h55, 8'h00}, '{0, `SFD_A_RXB, 8'h00, 8'h00},
        '{0, 3'h6, 8'h00, 8'h00}, '{0, 3'h7, 8'h00, 8'h00},
        '{1, `SFD_A_TXB, 8'ha5, 8'h00}, '{0, `SFD_A_TXB, 8'h00, 8'ha5},
        '{0, `SFD_A_STAT, 8'h00, 8'h80}, '{1, `SFD_A_FMT, 8'h7c, 8'h00},
        '{0, `SFD_A_FMT, 8'h00, 8'h7c}};
    sfd_tx_s txs [10] = '{
        '{8'h00, 8'h00, 8'h20, 8'ha5}, '{8'h40, 8'h00, 8'h20, 8'hc3},
        '{8'h20, 8'h00, 8'h20, 8'h07}, '{8'h30, 8'h00, 8'h20, 8'h07},
        '{8'h08, 8'h00, 8'h20, 8'h5a}, '{8'h34, 8'h00, 8'h21, 8'h3c},
        '{8'h01, 8'h00, 8'h20, 8'h96}, '{8'h02, 8'h00, 8'h20, 8'h96},
        '{8'h03, 8'h00, 8'h20, 8'h96}, '{8'h00, 8'h01, 8'h20, 8'h69}};
    sfd_rx_s rxs [5] = '{
        '{8'h00, 8'ha3, 24'h00_0000, 8'h40}, '{8'h40, 8'hff, 24'h00_0000, 8'h40},
        '{8'h20, 8'h5c, 24'h00_0200, 8'h50}, '{8'h30, 8'h5c, 24'h00_0000, 8'h40},
        '{8'h00, 8'h3c, 24'h00_0200, 8'h60}};

    initial forever #25 clk_i = ~clk_i;

    sfd_core i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .standby_i(standby_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(rdata_o), .rxd_i(rxd), .txd_o(txd_o), .sck_o(sck_o));
    sfd_peer i_peer (.clk_i(clk_i), .txd_i(txd_o), .sck_i(sck_o), .line_o(rxd));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [23:0] got, input logic [23:0] e, input string m);
        check_count++;
        if (got !== e) begin
            $display("Error at %0t ns: %s got %h expected %h", $time, m, got, e);
            bad_count++;
        end
    endtask : chk
    task automatic guard(input bit c);
        if (!c) begin
            chk(24'h00_0000, 24'h00_0001, "wait ran out");
            give_verdict();
        end
    endtask : guard
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        last = rdata_o;
        chk({16'h0000, rdata_o & m}, {16'h0000, e}, "register read");
    endtask : rd
    // wire image of one character, start bit at index 0, idle ones above
    function automatic int build(input logic [7:0] fm, input logic mb, input logic [7:0] d,
        output logic [23:0] fr);
        int nb;
        nb = fm[6] ? 7 : 8;
        fr = '1;
        fr[0] = 1'b0;
        for (int i = 0; i < nb; i++) fr[1 + i] = d[i];
        if (fm[2]) begin
            fr[nb + 1] = mb;
        end else if (fm[5]) begin
            fr[nb + 1] = ^d[6:0] ^ (fm[6] ? 1'b0 : d[7]) ^ fm[4];
        end
        return nb + 2 + (fm[3] ? 1 : 0) + ((fm[2] || fm[5]) ? 1 : 0);
    endfunction : build

    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        foreach (regs[i]) begin
            if (regs[i].we) wr(regs[i].a, regs[i].d);
            else rd(regs[i].a, regs[i].e, 8'hff);
        end
        $display("test registers done");
        foreach (txs[i]) begin
            wr(`SFD_A_FMT, txs[i].fmt);
            wr(`SFD_A_BRR, txs[i].brr);
            wr(`SFD_A_CTRL, txs[i].ctl);
            n = build(txs[i].fmt, txs[i].ctl[0], txs[i].d, f);
            per = (16 * (int'(txs[i].brr) + 1)) << (2 * int'(txs[i].fmt[1:0]));
            wr(`SFD_A_TXB, txs[i].d);
            i_peer.capture(n, per, h, ok);
            guard(ok);
            chk(h, f, "frame");
            rd(`SFD_A_STAT, 8'h80, 8'h80);
        end
        wr(`SFD_A_FMT, 8'h00);
        wr(`SFD_A_BRR, 8'h00);
        n = build(8'h00, 1'b0, 8'h81, f);
        void'(build(8'h00, 1'b0, 8'h7e, g));
        // second write lands in the cycle after the first byte is loaded
        fork
            begin
                wr(`SFD_A_TXB, 8'h81);
                wr(`SFD_A_TXB, 8'h7e);
            end
            i_peer.capture(2 * n, 16, h, ok);
        join
        guard(ok);
        chk(h, (f & ((24'h00_0001 << n) - 1)) | (g << n), "back to back");
        for (k = 0; k < 64; k++) begin
            @(negedge clk_i);
            if (txd_o !== 1'b1) chk({23'h00_0000, txd_o}, 24'h00_0001, "idle line");
        end
        $display("test transmit done");
        wr(`SFD_A_CTRL, 8'h30);
        foreach (rxs[i]) begin
            wr(`SFD_A_STAT, 8'h00);
            wr(`SFD_A_FMT, rxs[i].fmt);
            n = build(rxs[i].fmt, 1'b0, rxs[i].d, f);
            i_peer.send(f ^ rxs[i].flip, n, 16);
            rd(`SFD_A_RXB, rxs[i].fmt[6] ? rxs[i].d & 8'h7f : rxs[i].d, 8'hff);
            rd(`SFD_A_STAT, rxs[i].st, 8'h70);
            // a low stop bit looks like a new start; let that phantom frame drain
            repeat (192) @(posedge clk_i);
        end
        wr(`SFD_A_STAT, 8'h00);
        wr(`SFD_A_FMT, 8'h08);
        n = build(8'h00, 1'b0, 8'h11, f);
        void'(build(8'h00, 1'b0, 8'he8, g));
        i_peer.send((f & 24'h00_03ff) | (g << n), 2 * n, 16);
        rd(`SFD_A_RXB, 8'he8, 8'hff);
        rd(`SFD_A_STAT, 8'h40, 8'h70);
        $display("test receive done");
        wr(`SFD_A_FMT, 8'h80);
        wr(`SFD_A_STAT, 8'h00);
        fork
            wr(`SFD_A_TXB, 8'hb4);
            i_peer.sync_xfer(8'h2d, h8, ok);
        join
        guard(ok);
        chk({16'h0000, h8}, 24'h00_00b4, "clocked frame");
        last = 8'h00;
        for (k = 0; k < 40 && last[6] !== 1'b1; k++) rd(`SFD_A_STAT, 8'h00, 8'h00);
        guard(last[6] === 1'b1);
        rd(`SFD_A_RXB, 8'h2d, 8'hff);
        $display("test clocked done");
        @(posedge clk_i);
        standby_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        standby_i <= 1'b0;
        rd(`SFD_A_FMT, 8'h00, 8'hff);
        rd(`SFD_A_TXB, 8'hff, 8'hff);
        rd(`SFD_A_RXB, 8'h00, 8'hff);
        $display("test standby done");
        give_verdict();
    end
endmodule : tb_top
